// *** design/batch_setpoint_sequencer.sv ***
// setpoint engine: continuous compare, batch sequencer, avalon slave
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module batch_setpoint_sequencer (
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_i, // sync reset, high
  input wire logic ce_i, // clock enable
  input wire logic tick_i, // converter update pulse
  input wire logic signed [setpoint_pkg::WT_W-1:0] gross_i, // gross weight
  input wire logic signed [setpoint_pkg::WT_W-1:0] net_i, // net weight
  input wire logic signed [setpoint_pkg::WT_W-1:0] accumulator_compare_kind_i, // accumulator
  input wire logic signed [setpoint_pkg::WT_W-1:0] roc_i, // rate of change
  input wire logic start_pin_i, // digital start input
  input wire logic softkey_i, // start softkey pulse
  input wire logic [setpoint_pkg::ADDR_W-1:0] address_i, // byte address
  input wire logic read_i, // avalon read
  input wire logic write_i, // avalon write
  input wire logic [31:0] writedata_i, // avalon write data
  input wire logic [3:0] byteenable_i, // avalon lanes
  output logic [31:0] readdata_o, // avalon read data
  output logic waitrequest_o, // avalon wait
  output logic [setpoint_pkg::NUM_SP-1:0] dout_o, // setpoint outputs
  output logic busy_o // batch in progress
);
  import setpoint_pkg::*;

  // configuration and capture storage
  kind_e kind_q [NUM_SP];
  logic [NUM_SP-1:0] bat_q;
  logic [SP_W-1:0] ref_q [NUM_SP];
  logic signed [WT_W-1:0] target_q [NUM_SP];
  logic signed [WT_W-1:0] capt_q [NUM_SP];
  logic [1:0] mode_q;

  // per-setpoint vectors
  logic [NUM_SP-1:0] hit_vec;
  logic [NUM_SP-1:0] off_vec;
  logic [NUM_SP-1:0] bat_vec;
  logic [NUM_SP-1:0] cont_vec;
  logic [NUM_SP-1:0] cur_vec;
  logic signed [WT_W-1:0] val_vec [NUM_SP];

  // sequencer state
  state_e st_q;
  state_e st_d;
  logic [SP_W-1:0] step_q;
  logic [SP_W-1:0] step_d;
  logic [NUM_SP-1:0] latch_q;
  logic [NUM_SP-1:0] cont_q;
  logic [NUM_SP-1:0] out_d;
  logic adv;
  logic latch_set;
  logic clr_seq;

  // bus state
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic [31:0] wdm;

  // start input synchroniser
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;

  // address decode
  wire req = read_i | write_i;
  wire acc = req & ~wait_q;
  wire we = write_i & acc;
  wire is_sp = ~address_i[SP_AREA_BIT];
  wire is_tgt = address_i[SP_TGT_BIT];
  wire [SP_W-1:0] sp_sel = address_i[SP_IDX_LSB +: SP_W];
  wire is_ctrl = address_i[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2];
  wire is_stat = address_i[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2];
  wire is_out = address_i[ADDR_W-1:2] == OUT_OFS[ADDR_W-1:2];

  // readback words
  wire [31:0] cfg_word = ({28'h0, kind_q[sp_sel]} << CFG_KIND_LSB)
                       | ({31'h0, bat_q[sp_sel]} << CFG_BATCH_BIT)
                       | ({27'h0, ref_q[sp_sel]} << CFG_REF_LSB);
  wire [31:0] tgt_word = {8'h0, target_q[sp_sel]};
  wire [31:0] ctrl_word = {30'h0, mode_q} << CTRL_MODE_LSB;
  wire [31:0] stat_word = {27'h0, step_q}
                        | ({30'h0, st_q} << STAT_STATE_LSB)
                        | ({31'h0, busy_o} << STAT_BUSY_BIT);

  // unmapped addresses read as zero
  assign rd_mux = is_sp ? (is_tgt ? tgt_word : cfg_word) :
                  is_ctrl ? ctrl_word :
                  is_stat ? stat_word :
                  is_out ? dout_o : 32'h0;

  // byte lanes merge into the current word
  assign wmask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                  {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
  assign wdm = (rd_mux & ~wmask) | (writedata_i & wmask);

  wire start_cmd = we & is_ctrl & wdm[CTRL_START_BIT];
  wire start_any = (pin_s2_q & ~pin_s3_q) | softkey_i | start_cmd;

  // evaluation of all setpoints in parallel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SP; gi++) begin : g_sp
      setpoint_compare u_cmp (
        .kind_i(kind_q[gi]),
        .target_i(target_q[gi]),
        .ref_kind_i(kind_q[ref_q[gi]]),
        .ref_target_i(target_q[ref_q[gi]]),
        .ref_capt_i(capt_q[ref_q[gi]]),
        .gross_i(gross_i),
        .net_i(net_i),
        .accumulator_compare_kind_i(accumulator_compare_kind_i),
        .roc_i(roc_i),
        .hit_o(hit_vec[gi]),
        .val_o(val_vec[gi])
      );
      assign off_vec[gi] = kind_q[gi] == K_OFF;
      assign bat_vec[gi] = (kind_q[gi] == K_PAUSE) | (bat_q[gi] & ~off_vec[gi]);
      assign cont_vec[gi] = ~off_vec[gi] & ~bat_vec[gi];
      assign cur_vec[gi] = busy_o & (step_q == SP_W'(gi));
    end
  endgenerate

  // current step view
  wire cur_bat = bat_vec[step_q];
  wire cur_pause = kind_q[step_q] == K_PAUSE;
  wire cur_hit = hit_vec[step_q];
  wire last = step_q == SP_W'(NUM_SP - 1);

  // sequencer next state
  always_comb begin
    st_d = st_q;
    step_d = step_q;
    adv = 1'b0;
    latch_set = 1'b0;
    clr_seq = 1'b0;
    case (st_q)
      // auto runs at once, manual waits
      ST_IDLE: begin
        step_d = '0;
        st_d = (mode_q == MODE_AUTO) ? ST_RUN : ST_WAIT;
      end
      ST_WAIT: begin
        if (start_any) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!cur_bat) begin
          adv = 1'b1;
        end else if (cur_pause) begin
          st_d = ST_PAUSE;
        end else if (tick_i && cur_hit) begin
          latch_set = 1'b1;
          adv = 1'b1;
        end
      end
      ST_PAUSE: begin
        if (start_any) begin
          st_d = ST_RUN;
          adv = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (adv) begin
      if (last) begin
        clr_seq = 1'b1;
        step_d = '0;
        st_d = (mode_q == MODE_AUTO) ? ST_RUN : ST_WAIT;
      end else begin
        step_d = step_q + 1'b1;
      end
    end
    if (mode_q == MODE_OFF) begin
      st_d = ST_IDLE;
      step_d = '0;
      clr_seq = 1'b1;
      latch_set = 1'b0;
    end
  end

  // continuous follows condition, batch pending or latched
  assign out_d = (cont_q & cont_vec) | ((latch_q | cur_vec) & bat_vec);

  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      step_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
      step_q <= step_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_q <= '0;
    end else if (ce_i && clr_seq) begin
      latch_q <= '0;
    end else if (ce_i && latch_set) begin
      latch_q[step_q] <= 1'b1;
    end
  end

  // capture value of a satisfied step for relative kinds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SP; i++) begin
        capt_q[i] <= '0;
      end
    end else if (ce_i && latch_set) begin
      capt_q[step_q] <= val_vec[step_q];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cont_q <= '0;
    end else if (ce_i && tick_i) begin
      cont_q <= hit_vec & cont_vec;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_o <= '0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      dout_o <= out_d;
      busy_o <= (st_d == ST_RUN) | (st_d == ST_PAUSE);
    end
  end

  // start pin crosses in on two flops, third for the edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else if (ce_i) begin
      pin_s1_q <= start_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // one wait cycle per access keeps read data registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else if (ce_i) begin
      wait_q <= ~(req & wait_q);
      if (req && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign waitrequest_o = wait_q;
  assign readdata_o = rdata_q;

  // setpoint configuration writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bat_q <= '0;
      for (int i = 0; i < NUM_SP; i++) begin
        kind_q[i] <= K_OFF;
        ref_q[i] <= '0;
        target_q[i] <= '0;
      end
    end else if (ce_i && we && is_sp) begin
      if (is_tgt) begin
        target_q[sp_sel] <= wdm[WT_W-1:0];
      end else begin
        kind_q[sp_sel] <= kind_e'(wdm[CFG_KIND_LSB +: 4]);
        bat_q[sp_sel] <= wdm[CFG_BATCH_BIT];
        ref_q[sp_sel] <= wdm[CFG_REF_LSB +: SP_W];
      end
    end
  end

  // batching mode select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_RST;
    end else if (ce_i && we && is_ctrl) begin
      mode_q <= wdm[CTRL_MODE_LSB +: 2];
    end
  end

  // checks
  // off outputs low
  off_out_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> (dout_o & $past(off_vec)) == '0)
    else $error("off setpoint drives its output");

  cont_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && tick_i) ##1 ce_i |=>
      ((dout_o ^ $past(hit_vec, 2)) & $past(cont_vec, 2) & $past(cont_vec)) == '0)
    else $error("continuous output does not follow its condition");

  step_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_q == ST_RUN |=> step_q == $past(step_q) || step_q == $past(step_q) + 1'b1 || step_q == '0)
    else $error("batch step jumped out of order");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !clr_seq |=> ($past(latch_q) & ~latch_q) == '0)
    else $error("batch latch dropped mid sequence");

  batch_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> (dout_o & $past(bat_vec) & ~$past(latch_q) & ~$past(cur_vec)) == '0)
    else $error("batch output on while neither pending nor latched");

  manual_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_q == ST_WAIT && !start_any && mode_q == MODE_MANUAL |=> st_q == ST_WAIT)
    else $error("manual sequence began without start");

  start_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_q == ST_WAIT && start_any && mode_q != MODE_OFF |=> st_q == ST_RUN ##1 busy_o || !ce_i)
    else $error("start signal did not begin the sequence");

  pause_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_q == ST_PAUSE && !start_any && mode_q != MODE_OFF |=> st_q == ST_PAUSE && $stable(step_q))
    else $error("pause step left without start");

  end_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && clr_seq |=> latch_q == '0 && step_q == '0)
    else $error("sequence end did not clear latches");

endmodule : batch_setpoint_sequencer

// *** design/setpoint_compare.sv ***
// condition and capture value of one setpoint
`timescale 1ns/1ps
module setpoint_compare (
  input wire setpoint_pkg::kind_e kind_i, // own kind
  input wire logic signed [setpoint_pkg::WT_W-1:0] target_i, // own target
  input wire setpoint_pkg::kind_e ref_kind_i, // referenced kind
  input wire logic signed [setpoint_pkg::WT_W-1:0] ref_target_i, // referenced target
  input wire logic signed [setpoint_pkg::WT_W-1:0] ref_capt_i, // referenced capture
  input wire logic signed [setpoint_pkg::WT_W-1:0] gross_i, // gross weight
  input wire logic signed [setpoint_pkg::WT_W-1:0] net_i, // net weight
  input wire logic signed [setpoint_pkg::WT_W-1:0] accumulator_compare_kind_i, // accumulator
  input wire logic signed [setpoint_pkg::WT_W-1:0] roc_i, // rate of change
  output logic hit_o, // condition met
  output logic signed [setpoint_pkg::WT_W-1:0] val_o // value to capture
);
  import setpoint_pkg::*;

  logic signed [47:0] prod;
  logic signed [WT_W-1:0] eff;

  // weight modes; inputs already in primary units, no conversion here
  // primary units
  function automatic logic wt_hit(input kind_e m, input logic signed [WT_W-1:0] e,
                                  input logic signed [WT_W-1:0] g, input logic signed [WT_W-1:0] n);
    case (m)
      K_GROSS: wt_hit = g >= e;
      K_NET: wt_hit = n >= e;
      K_NGROSS: wt_hit = g <= -e;
      K_NNET: wt_hit = n <= -e;
      default: wt_hit = 1'b0;
    endcase
  endfunction : wt_hit

  function automatic logic signed [WT_W-1:0] wt_val(input kind_e m, input logic signed [WT_W-1:0] g,
                                                    input logic signed [WT_W-1:0] n);
    case (m)
      K_GROSS, K_NGROSS: wt_val = g;
      K_NET, K_NNET: wt_val = n;
      default: wt_val = '0;
    endcase
  endfunction : wt_val

  // effective target and compare
  always_comb begin
    prod = '0;
    eff = target_i;
    hit_o = 1'b0;
    val_o = '0;
    case (kind_i)
      K_GROSS, K_NET, K_NGROSS, K_NNET: begin
        hit_o = wt_hit(kind_i, target_i, gross_i, net_i);
        val_o = wt_val(kind_i, gross_i, net_i);
      end
      K_ACCUMULATOR_COMPARE_KIND: begin
        hit_o = accumulator_compare_kind_i >= target_i;
        val_o = accumulator_compare_kind_i;
      end
      K_SLOPE: begin
        hit_o = roc_i >= target_i;
        val_o = roc_i;
      end
      K_ABOVE, K_BELOW, K_PCT_TGT, K_PCT_CAPT: begin
        if (kind_i == K_ABOVE) begin
          eff = ref_target_i + target_i;
        end else if (kind_i == K_BELOW) begin
          eff = ref_target_i - target_i;
        end else if (kind_i == K_PCT_TGT) begin
          // widen before multiplying so large targets cannot wrap at 24 bits
          prod = 48'(ref_target_i) * 48'(target_i);
          eff = WT_W'(prod / PCT_DIV);
        end else begin
          prod = 48'(ref_capt_i) * 48'(target_i);
          eff = WT_W'(prod / PCT_DIV);
        end
        hit_o = wt_hit(ref_kind_i, eff, gross_i, net_i);
        val_o = wt_val(ref_kind_i, gross_i, net_i);
      end
      default: begin
        hit_o = 1'b0;
        val_o = '0;
      end
    endcase
  end
endmodule : setpoint_compare

// *** design/setpoint_pkg.sv ***
// constants and types shared by the setpoint sequencer files
package setpoint_pkg;
  localparam int NUM_SP = 32;
  localparam int SP_W = 5;
  localparam int WT_W = 24;
  localparam int ADDR_W = 9;

  // byte offsets; setpoint i config at 8*i, target at 8*i+4
  localparam logic [ADDR_W-1:0] CTRL_OFS = 9'h100;
  localparam logic [ADDR_W-1:0] STAT_OFS = 9'h104;
  localparam logic [ADDR_W-1:0] OUT_OFS = 9'h108;
  localparam int SP_AREA_BIT = 8;
  localparam int SP_IDX_LSB = 3;
  localparam int SP_TGT_BIT = 2;

  // field positions
  localparam int CFG_KIND_LSB = 0;
  localparam int CFG_BATCH_BIT = 4;
  localparam int CFG_REF_LSB = 8;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_START_BIT = 8;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_BUSY_BIT = 16;

  // batching mode select codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_MANUAL = 2'h2;
  localparam logic [1:0] MODE_RST = 2'h0;

  localparam logic signed [47:0] PCT_DIV = 48'sh64;

  typedef enum logic [3:0] {
    K_OFF = 4'h0,
    K_GROSS = 4'h1,
    K_NET = 4'h2,
    K_NGROSS = 4'h3,
    K_NNET = 4'h4,
    K_ACCUMULATOR_COMPARE_KIND = 4'h5,
    K_SLOPE = 4'h6,
    K_ABOVE = 4'h7,
    K_BELOW = 4'h8,
    K_PCT_TGT = 4'h9,
    K_PCT_CAPT = 4'ha,
    K_PAUSE = 4'hb
  } kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10,
    ST_PAUSE = 2'b11
  } state_e;
endpackage : setpoint_pkg

// *** verif/scale_model.sv ***
// scale side stand-in: weight readings and converter update ticks
`timescale 1ns/1ps
module scale_model (
  input wire logic clk_i, // bench clock
  output logic tick_o, // converter update pulse
  output logic signed [setpoint_pkg::WT_W-1:0] gross_o, // gross weight
  output logic signed [setpoint_pkg::WT_W-1:0] net_o, // net weight
  output logic signed [setpoint_pkg::WT_W-1:0] accumulator_compare_kind_o, // accumulator
  output logic signed [setpoint_pkg::WT_W-1:0] roc_o // rate of change
);
  import setpoint_pkg::*;
  // quiet scale at power up, no update pending
  initial begin
    tick_o = 1'b0;
    gross_o = '0;
    net_o = '0;
    accumulator_compare_kind_o = '0;
    roc_o = '0;
  end
  // new reading in primary units; the tick, if asked, stands one clock only
  task automatic apply(input logic signed [WT_W-1:0] g, input logic signed [WT_W-1:0] n,
                       input logic signed [WT_W-1:0] a, input logic signed [WT_W-1:0] r, input logic t);
    @(posedge clk_i);
    gross_o <= g;
    net_o <= n;
    accumulator_compare_kind_o <= a;
    roc_o <= r;
    tick_o <= t;
    @(posedge clk_i);
    tick_o <= 1'b0;
  endtask : apply
endmodule : scale_model

// *** verif/test_batch_setpoint_sequencer.sv ***
// self-checking bench for the setpoint sequencer
`timescale 1ns/1ps
module test_batch_setpoint_sequencer;
  import setpoint_pkg::*;
  logic clk_i, rst_i, ce_i, tick_i, start_pin_i, softkey_i, read_i, write_i, waitrequest_o, busy_o;
  logic [ADDR_W-1:0] address_i;
  logic [31:0] writedata_i, readdata_o, rd;
  logic [3:0] byteenable_i;
  logic [NUM_SP-1:0] dout_o;
  logic signed [WT_W-1:0] gross_i, net_i, accumulator_compare_kind_i, roc_i;
  logic [ADDR_W-1:0] ra [6] = '{CTRL_OFS, STAT_OFS, OUT_OFS, 9'h10c, 9'h000, 9'h004};
  int err_count, cmp_count;

  batch_setpoint_sequencer batch_setpoint_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(tick_i), .gross_i(gross_i), .net_i(net_i),
    .accumulator_compare_kind_i(accumulator_compare_kind_i), .roc_i(roc_i), .start_pin_i(start_pin_i), .softkey_i(softkey_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .dout_o(dout_o), .busy_o(busy_o)
  );
  scale_model scale_model_inst (
    .clk_i(clk_i), .tick_o(tick_i), .gross_o(gross_i), .net_o(net_i), .accumulator_compare_kind_o(accumulator_compare_kind_i), .roc_o(roc_i)
  );

  // free-running 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // one avalon access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) begin
        err_count++;
        summarize();
      end
    end while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : bus

  // config word then target of one setpoint
  task automatic sp(input int i, input kind_e k, input logic b, input int r, input int t);
    bus(1'b1, 9'(8 * i), {19'h0, 5'(r), 3'h0, b, k});
    bus(1'b1, 9'(8 * i + 4), 32'(t));
  endtask : sp

  // poll status until the masked value shows up; a hang ends the run
  task automatic wait_stat(input logic [31:0] exp, input logic [31:0] m);
    int n = 0;
    do begin
      bus(1'b0, STAT_OFS, 32'h0);
      n++;
      if (n > 60) begin
        err_count++;
        summarize();
      end
    end while ((rd & m) !== exp);
    cmp_count++;
  endtask : wait_stat

  // converter update, then let the two-edge output latency pass
  task automatic upd(input int g, input int n, input int a, input int r);
    scale_model_inst.apply(g, n, a, r, 1'b1);
    repeat (3) @(posedge clk_i);
  endtask : upd

  // start pulse: pin held a few clocks to clear its synchroniser, softkey one clock
  task automatic kick(input logic pin);
    @(posedge clk_i);
    start_pin_i <= pin;
    softkey_i <= !pin;
    repeat (pin ? 4 : 1) @(posedge clk_i);
    start_pin_i <= 1'b0;
    softkey_i <= 1'b0;
  endtask : kick

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    start_pin_i = 1'b0;
    softkey_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = '0;
    writedata_i = '0;
    byteenable_i = 4'hf;
    err_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    check(dout_o, 32'h0);
    check({30'h0, busy_o, waitrequest_o}, 32'h1);
    bus(1'b1, 9'h10c, 32'hffffffff);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      check(rd, 32'h0);
    end
    $display("reset test done");

    // continuous setpoints kept below the batch range
    sp(0, K_GROSS, 1'b0, 0, 100);
    sp(1, K_NET, 1'b0, 0, 100);
    sp(2, K_NGROSS, 1'b0, 0, 100);
    sp(3, K_NNET, 1'b0, 0, 100);
    sp(4, K_ACCUMULATOR_COMPARE_KIND, 1'b0, 0, 100);
    sp(5, K_SLOPE, 1'b0, 0, 100);
    sp(6, K_ABOVE, 1'b0, 0, 20);
    sp(7, K_BELOW, 1'b0, 0, 20);
    sp(8, K_PCT_TGT, 1'b0, 0, 50);
    upd(100, 99, 100, 99);
    check(dout_o, 32'h191);
    upd(-100, -101, 99, 100);
    check(dout_o, 32'h2c);
    scale_model_inst.apply(120, 100, -5, -100, 1'b0);
    repeat (4) @(posedge clk_i);
    check(dout_o, 32'h2c);
    upd(120, 100, -5, -100);
    check(dout_o, 32'h1c3);
    $display("continuous test done");

    sp(10, K_GROSS, 1'b1, 0, 100);
    sp(11, K_NET, 1'b1, 0, 50);
    sp(12, K_PCT_CAPT, 1'b0, 10, 50);
    bus(1'b1, CTRL_OFS, 32'(MODE_AUTO));
    wait_stat(32'h1020a, 32'h1031f);
    check({31'h0, busy_o}, 32'h1);
    check(dout_o & 32'hc00, 32'h400);
    upd(160, 0, 0, 0);
    wait_stat(32'h1020b, 32'h1031f);
    check(dout_o & 32'hc00, 32'hc00);
    upd(79, 0, 0, 0);
    check(dout_o & 32'h1c00, 32'hc00);
    upd(80, 0, 0, 0);
    check(dout_o & 32'h1c00, 32'h1c00);
    upd(80, 50, 0, 0);
    wait_stat(32'h1020a, 32'h1031f);
    check(dout_o & 32'hc00, 32'h400);
    $display("auto batch test done");

    bus(1'b1, CTRL_OFS, 32'(MODE_OFF));
    wait_stat(32'h0, 32'h10300);
    check(dout_o & 32'hc00, 32'h0);
    kick(1'b0);
    bus(1'b0, STAT_OFS, 32'h0);
    check(rd & 32'h10300, 32'h0);
    $display("mode off test done");

    sp(11, K_PAUSE, 1'b0, 0, 0);
    bus(1'b1, CTRL_OFS, 32'(MODE_MANUAL));
    wait_stat(32'h100, 32'h10300);
    kick(1'b0);
    wait_stat(32'h1020a, 32'h1031f);
    upd(160, 0, 0, 0);
    wait_stat(32'h1030b, 32'h1031f);
    check(dout_o & 32'hc00, 32'hc00);
    upd(160, 0, 0, 0);
    bus(1'b0, STAT_OFS, 32'h0);
    check(rd & 32'h1031f, 32'h1030b);
    kick(1'b1);
    wait_stat(32'h100, 32'h10300);
    check(dout_o & 32'hc00, 32'h0);
    bus(1'b1, CTRL_OFS, 32'h102);
    wait_stat(32'h1020a, 32'h1031f);
    check(dout_o & 32'hffffe200, 32'h0);
    bus(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h2);
    // lane 0 only: the upper target bytes keep their old value
    byteenable_i <= 4'h1;
    bus(1'b1, 9'h064, 32'hffffff3c);
    byteenable_i <= 4'hf;
    bus(1'b0, 9'h064, 32'h0);
    check(rd, 32'h3c);
    bus(1'b0, 9'h060, 32'h0);
    check(rd, 32'ha0a);
    // frozen clock enable swallows a tick that would satisfy step 10
    @(posedge clk_i);
    ce_i <= 1'b0;
    upd(160, 0, 0, 0);
    ce_i <= 1'b1;
    bus(1'b0, STAT_OFS, 32'h0);
    check(rd & 32'h1031f, 32'h1020a);
    // reset in mid-run drops outputs, busy and mode
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check(dout_o, 32'h0);
    check({30'h0, busy_o, waitrequest_o}, 32'h1);
    bus(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, CTRL_OFS, 32'(MODE_OFF));
    $display("manual batch test done");
    summarize();
  end
endmodule : test_batch_setpoint_sequencer
